// File: hdl/pic_ctrl.sv
// Interrupt control words, edge capture and service sequencer
`timescale 1ns/10ps
`include "pic_consts.svh"

// Overview of operation
// (RULE_01) Reset/stop-release vector 0; sources priority 1..7, vectors 2..E.
// (RULE_02) Stop-release honoured only while in stop mode.
// (RULE_03) Highest-priority unmasked pending source is chosen.
// (RULE_04) Global enable in word 0 bit 0 gates all processing.
// (RULE_05) Enable cleared on service, set by return-from-interrupt.
// (RULE_06) External flags set on rising edges of external inputs.
// (RULE_07) External masks: 0 passes, 1 blocks.
// (RULE_08) Timer A flag set on each overflow.
// (RULE_09) Timer A mask in word 1 bit 3.
// (RULE_10) Timer B flag set on each overflow.
// (RULE_11) Timer B mask in word 2 bit 1.
// (RULE_12) Timer C flag set on each overflow.
// (RULE_13) Timer C mask in word 2 bit 3.
// (RULE_14) Serial flag set on transfer end or suspension.
// (RULE_15) Serial mask in word 3 bit 3.
// (RULE_16) Converter flag set when conversion finishes.
// (RULE_17) Converter mask in word 3 bit 1.
// (RULE_18) Request is flag and not mask; processed only if enabled.
// (RULE_19) Three-cycle service: finish, clear enable and push, jump.
// (RULE_20) Reset clears enable and flags, sets all masks.
// (RULE_21) Software writes never set flags; handler clears them.
// (RULE_22) Lower-priority requests stay pending while one is served.
// (RULE_23) Hardware set wins over a same-cycle software clear.
module pic_ctrl (
	// Clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RSTN,
	// Control word access from the core
	input  wire logic [1:0]  ADDR,
	input  wire logic        WR_EN,
	input  wire logic [3:0]  WR_DATA,
	input  wire logic        RD_EN,
	output logic [3:0]       RD_DATA,
	// Event sources, one-cycle pulses except the external inputs
	input  wire logic        EXT_IRQ_IN0,
	input  wire logic        EXT_IRQ_IN1,
	input  wire logic        TMRA_OVF,
	input  wire logic        TMRB_OVF,
	input  wire logic        TMRC_OVF,
	input  wire logic        ADC_DONE,
	input  wire logic        SERIAL_DONE,
	input  wire logic        SERIAL_SUSPEND,
	// Core status and stop release
	input  wire logic        STOP_MODE,
	input  wire logic        STOP_RELEASE_IN,
	input  wire logic        RETURN_FROM_IRQ_INSTR,
	input  wire logic        INSTR_DONE,
	// Service sequence outputs
	output logic             IRQ_ACK,
	output logic             PUSH_STATE,
	output logic             VEC_LOAD,
	output logic [13:0]      VEC_ADDR,
	output logic             STOP_RELEASE,
	output logic             GLOBAL_IRQ_ENABLE
);

	// ****************************************
	// Storage
	// ****************************************
	logic                    global_irq_enable_ff;
	logic [6:0]              req_flag_ff;
	logic [6:0]              request_mask_ff;
	logic [6:0]              set_evt;
	logic [6:0]              clr_evt;
	logic [6:0]              pending;
	logic                    ext0_d_ff;
	logic                    ext1_d_ff;
	logic                    pe_any;
	logic [13:0]             pe_vec;
	logic [6:0]              pend_d_ff;
	logic [3:0]              rd_word;
	logic                    clr_gie;
	pic_pkg::pic_state_e     state_ff;
	pic_pkg::pic_state_e     nxt_state;

	// Flag order: ext0, ext1, tmra, tmrb, tmrc, adc, serial
	wire w0 = WR_EN && (ADDR == `PIC_ADDR_WORD0);
	wire w1 = WR_EN && (ADDR == `PIC_ADDR_WORD1);
	wire w2 = WR_EN && (ADDR == `PIC_ADDR_WORD2);
	wire w3 = WR_EN && (ADDR == `PIC_ADDR_WORD3);

	// ****************************************
	// Named views of the control bits
	// ****************************************

	// One name per bit keeps the read map legible
	wire ext0_request_flag   = req_flag_ff[0];
	wire ext1_request_flag   = req_flag_ff[1];
	wire tmra_request_flag   = req_flag_ff[2];
	wire tmrb_request_flag   = req_flag_ff[3];
	wire tmrc_request_flag   = req_flag_ff[4];
	wire adc_request_flag    = req_flag_ff[5];
	wire serial_request_flag = req_flag_ff[6];
	wire ext0_mask           = request_mask_ff[0];
	wire ext1_mask           = request_mask_ff[1];
	wire tmra_mask           = request_mask_ff[2];
	wire tmrb_mask           = request_mask_ff[3];
	wire tmrc_mask           = request_mask_ff[4];
	wire adc_mask            = request_mask_ff[5];
	wire serial_mask         = request_mask_ff[6];

	// ****************************************
	// Event capture
	// ****************************************

	// Previous level of external inputs for rising edge detect
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ext0_d_ff <= 1'b0;
			ext1_d_ff <= 1'b0;
		end else begin
			ext0_d_ff <= EXT_IRQ_IN0;
			ext1_d_ff <= EXT_IRQ_IN1;
		end
	end

	// Hardware set events per source
	always_comb begin
		set_evt[0] = EXT_IRQ_IN0 && !ext0_d_ff; // RULE_06
		set_evt[1] = EXT_IRQ_IN1 && !ext1_d_ff; // RULE_06
		set_evt[2] = TMRA_OVF; // RULE_08
		set_evt[3] = TMRB_OVF; // RULE_10
		set_evt[4] = TMRC_OVF; // RULE_12
		set_evt[5] = ADC_DONE; // RULE_16
		set_evt[6] = SERIAL_DONE || SERIAL_SUSPEND; // RULE_14
	end

	// Software clears: writing 0 to a flag clears it, 1 leaves it
	always_comb begin
		clr_evt[0] = w0 && !WR_DATA[`PIC_W0_EXT0_F_BIT];
		clr_evt[1] = w1 && !WR_DATA[`PIC_W1_EXT1_F_BIT];
		clr_evt[2] = w1 && !WR_DATA[`PIC_W1_TMRA_F_BIT];
		clr_evt[3] = w2 && !WR_DATA[`PIC_W2_TMRB_F_BIT];
		clr_evt[4] = w2 && !WR_DATA[`PIC_W2_TMRC_F_BIT];
		clr_evt[5] = w3 && !WR_DATA[`PIC_W3_ADC_F_BIT];
		clr_evt[6] = w3 && !WR_DATA[`PIC_W3_SER_F_BIT];
	end

	// Request flags; the sequencer never touches them
	genvar g;
	generate
		for (g = 0; g < `PIC_NUM_SRC; g++) begin : g_flag
			always_ff @(posedge REF_CLK or negedge RSTN) begin
				if (!RSTN) begin
					req_flag_ff[g] <= 1'b0; // RULE_20
				end else if (set_evt[g]) begin
					req_flag_ff[g] <= 1'b1; // RULE_23
				end else if (clr_evt[g]) begin
					req_flag_ff[g] <= 1'b0; // RULE_21
				end
			end
		end
	endgenerate

	// ****************************************
	// Masks and global enable
	// ****************************************

	// Masks written directly; 1 blocks the source
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			request_mask_ff <= `PIC_RST_MASKS; // RULE_20
		end else begin
			if (w0) begin
				request_mask_ff[0] <= WR_DATA[`PIC_W0_EXT0_M_BIT]; // RULE_07
			end
			if (w1) begin
				request_mask_ff[1] <= WR_DATA[`PIC_W1_EXT1_M_BIT]; // RULE_07
				request_mask_ff[2] <= WR_DATA[`PIC_W1_TMRA_M_BIT]; // RULE_09
			end
			if (w2) begin
				request_mask_ff[3] <= WR_DATA[`PIC_W2_TMRB_M_BIT]; // RULE_11
				request_mask_ff[4] <= WR_DATA[`PIC_W2_TMRC_M_BIT]; // RULE_13
			end
			if (w3) begin
				request_mask_ff[5] <= WR_DATA[`PIC_W3_ADC_M_BIT]; // RULE_17
				request_mask_ff[6] <= WR_DATA[`PIC_W3_SER_M_BIT]; // RULE_15
			end
		end
	end

	// Service clear has priority so a handler cannot be re-entered
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			global_irq_enable_ff <= `PIC_RST_GIE; // RULE_20
		end else if (clr_gie) begin
			global_irq_enable_ff <= 1'b0; // RULE_05
		end else if (RETURN_FROM_IRQ_INSTR) begin
			global_irq_enable_ff <= 1'b1; // RULE_05
		end else if (w0) begin
			global_irq_enable_ff <= WR_DATA[`PIC_W0_GIE_BIT]; // RULE_04
		end
	end

	// ****************************************
	// Priority selection
	// ****************************************

	// Request raised per source regardless of enable
	assign pending = req_flag_ff & ~request_mask_ff; // RULE_18

	// Encoder result lags one cycle; remember the requests it saw
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			pend_d_ff <= `PIC_RST_FLAGS;
		end else begin
			pend_d_ff <= pending;
		end
	end

	pic_prio_enc u_enc (
		.REF_CLK (REF_CLK),
		.RSTN    (RSTN),
		.req     (pending),
		.any_ff  (pe_any),
		.idx_ff  (),
		.vec_ff  (pe_vec)
	);

	// ****************************************
	// Service sequencer
	// ****************************************

	// Acknowledge only with enable set and pending unmasked source;
	// waits while requests change so the vector never names a stale
	// source, at the cost of a cycle after each new arrival
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			pic_pkg::PIC_IDLE: begin
				if (pe_any && global_irq_enable_ff && !STOP_MODE &&
				    (pending == pend_d_ff)) begin // RULE_03
					nxt_state = pic_pkg::PIC_CYC1; // RULE_18
				end
			end
			pic_pkg::PIC_CYC1: begin
				if (INSTR_DONE) begin
					nxt_state = pic_pkg::PIC_CYC2; // RULE_19
				end
			end
			pic_pkg::PIC_CYC2: nxt_state = pic_pkg::PIC_CYC3; // RULE_19
			pic_pkg::PIC_CYC3: nxt_state = pic_pkg::PIC_IDLE;
			default:           nxt_state = pic_pkg::PIC_IDLE;
		endcase
	end

	assign clr_gie = (state_ff == pic_pkg::PIC_CYC1) && INSTR_DONE;

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_ff <= pic_pkg::PIC_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Sequence strobes; vector frozen at acknowledge so later
	// arrivals of any priority wait for the next service
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			IRQ_ACK    <= 1'b0;
			PUSH_STATE <= 1'b0;
			VEC_LOAD   <= 1'b0;
			VEC_ADDR   <= `PIC_VEC_RESET;
		end else begin
			IRQ_ACK    <= (state_ff == pic_pkg::PIC_IDLE) &&
			              (nxt_state == pic_pkg::PIC_CYC1);
			PUSH_STATE <= (nxt_state == pic_pkg::PIC_CYC2) ||
			              (nxt_state == pic_pkg::PIC_CYC3); // RULE_19
			VEC_LOAD   <= (nxt_state == pic_pkg::PIC_CYC3) ||
			              (STOP_RELEASE_IN && STOP_MODE);
			if (STOP_RELEASE_IN && STOP_MODE) begin
				VEC_ADDR <= `PIC_VEC_RESET; // RULE_01
			end else if (state_ff == pic_pkg::PIC_IDLE &&
			             nxt_state == pic_pkg::PIC_CYC1) begin
				VEC_ADDR <= pe_vec; // RULE_22
			end
		end
	end

	// Stop release ignored outside stop mode
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			STOP_RELEASE <= 1'b0;
		end else begin
			STOP_RELEASE <= STOP_RELEASE_IN && STOP_MODE; // RULE_02
		end
	end

	// Output copy of the enable with the same priority, so the core
	// never sees a value that lags the enable itself
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			GLOBAL_IRQ_ENABLE <= `PIC_RST_GIE; // RULE_20
		end else if (clr_gie) begin
			GLOBAL_IRQ_ENABLE <= 1'b0; // RULE_05
		end else if (RETURN_FROM_IRQ_INSTR) begin
			GLOBAL_IRQ_ENABLE <= 1'b1; // RULE_05
		end else if (w0) begin
			GLOBAL_IRQ_ENABLE <= WR_DATA[`PIC_W0_GIE_BIT]; // RULE_04
		end
	end

	// Read word built from the field positions, so both maps agree;
	// the unused bit of word 0 reads as zero
	always_comb begin
		rd_word = 4'h0;
		if (ADDR == `PIC_ADDR_WORD0) begin
			rd_word[`PIC_W0_GIE_BIT]    = global_irq_enable_ff;
			rd_word[`PIC_W0_EXT0_F_BIT] = ext0_request_flag;
			rd_word[`PIC_W0_EXT0_M_BIT] = ext0_mask;
		end else if (ADDR == `PIC_ADDR_WORD1) begin
			rd_word[`PIC_W1_EXT1_F_BIT] = ext1_request_flag;
			rd_word[`PIC_W1_EXT1_M_BIT] = ext1_mask;
			rd_word[`PIC_W1_TMRA_F_BIT] = tmra_request_flag;
			rd_word[`PIC_W1_TMRA_M_BIT] = tmra_mask;
		end else if (ADDR == `PIC_ADDR_WORD2) begin
			rd_word[`PIC_W2_TMRB_F_BIT] = tmrb_request_flag;
			rd_word[`PIC_W2_TMRB_M_BIT] = tmrb_mask;
			rd_word[`PIC_W2_TMRC_F_BIT] = tmrc_request_flag;
			rd_word[`PIC_W2_TMRC_M_BIT] = tmrc_mask;
		end else begin
			rd_word[`PIC_W3_ADC_F_BIT]  = adc_request_flag;
			rd_word[`PIC_W3_ADC_M_BIT]  = adc_mask;
			rd_word[`PIC_W3_SER_F_BIT]  = serial_request_flag;
			rd_word[`PIC_W3_SER_M_BIT]  = serial_mask;
		end
	end

	// Registered read; data holds between reads
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			RD_DATA <= 4'h0;
		end else if (RD_EN) begin
			RD_DATA <= rd_word;
		end
	end

endmodule : pic_ctrl

// File: include/pic_consts.svh
// Constants for the prioritized interrupt control block
`ifndef PIC_CONSTS_SVH
`define PIC_CONSTS_SVH

// ****************************************
// Control word locations
// ****************************************
`define PIC_ADDR_WORD0      2'h0
`define PIC_ADDR_WORD1      2'h1
`define PIC_ADDR_WORD2      2'h2
`define PIC_ADDR_WORD3      2'h3

// ****************************************
// Field positions
// ****************************************
`define PIC_W0_GIE_BIT      0
`define PIC_W0_EXT0_F_BIT   2
`define PIC_W0_EXT0_M_BIT   3
`define PIC_W1_EXT1_F_BIT   0
`define PIC_W1_EXT1_M_BIT   1
`define PIC_W1_TMRA_F_BIT   2
`define PIC_W1_TMRA_M_BIT   3
`define PIC_W2_TMRB_F_BIT   0
`define PIC_W2_TMRB_M_BIT   1
`define PIC_W2_TMRC_F_BIT   2
`define PIC_W2_TMRC_M_BIT   3
`define PIC_W3_ADC_F_BIT    0
`define PIC_W3_ADC_M_BIT    1
`define PIC_W3_SER_F_BIT    2
`define PIC_W3_SER_M_BIT    3

// ****************************************
// Reset values and vectors
// ****************************************
`define PIC_RST_FLAGS       7'h00
`define PIC_RST_MASKS       7'h7F
`define PIC_RST_GIE         1'b0
`define PIC_VEC_RESET       14'h0000
`define PIC_VEC_BASE        14'h0002
`define PIC_VEC_STEP        14'h0002
`define PIC_NUM_SRC         7

`endif

// File: include/pic_pkg.sv
// Types for the prioritized interrupt control block
package pic_pkg;

	// Service sequence states
	typedef enum logic [1:0] {
		PIC_IDLE,
		PIC_CYC1,
		PIC_CYC2,
		PIC_CYC3
	} pic_state_e;

	// Source index order, priority 1 first
	typedef logic [6:0] pic_src_t;

endpackage : pic_pkg

// File: hdl/pic_prio_enc.sv
// Fixed priority encoder turning pending requests into a vector
`timescale 1ns/10ps
`include "pic_consts.svh"

module pic_prio_enc (
	// Clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RSTN,
	// Requests, bit 0 highest priority
	input  wire logic [6:0]  req,
	// Registered result
	output logic             any_ff,
	output logic [2:0]       idx_ff,
	output logic [13:0]      vec_ff
);

	logic [2:0] nxt_idx;
	logic       nxt_any;

	// Lowest index wins; lower sources never disturb the choice
	always_comb begin
		nxt_idx = 3'h0;
		nxt_any = 1'b0;
		for (int i = `PIC_NUM_SRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				nxt_idx = 3'(i); // RULE_03
				nxt_any = 1'b1;
			end
		end
	end

	// Registered so the vector is glitch-free at the sequencer
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			any_ff <= 1'b0;
			idx_ff <= 3'h0;
			vec_ff <= `PIC_VEC_RESET;
		end else begin
			any_ff <= nxt_any;
			idx_ff <= nxt_idx;
			// Vectors rise by two from the first source
			vec_ff <= `PIC_VEC_BASE + `PIC_VEC_STEP * {11'h000, nxt_idx}; // RULE_01
		end
	end

endmodule : pic_prio_enc

// File: dv/pic_checker.sv
// Port assertions for the interrupt control block
`timescale 1ns/10ps
// *****
// Checker
// *****
module pic_checker (
	// Clock and reset
	input wire logic        REF_CLK,
	input wire logic        RSTN,
	// Watched ports
	input wire logic        STOP_MODE,
	input wire logic        STOP_RELEASE_IN,
	input wire logic        IRQ_ACK,
	input wire logic        PUSH_STATE,
	input wire logic        VEC_LOAD,
	input wire logic [13:0] VEC_ADDR,
	input wire logic        STOP_RELEASE,
	input wire logic        GLOBAL_IRQ_ENABLE
);
	// One domain, so one clock and one disable
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);
	// Service sequence shape
	AST_ACK_PULSE: assert property (IRQ_ACK |=> !IRQ_ACK)
		else $error("ack wider than one cycle");
	AST_PUSH_TWO: assert property ($rose(PUSH_STATE) |=>
		PUSH_STATE ##1 !PUSH_STATE) else $error("push not two cycles");
	AST_LOAD_JUMP: assert property ($rose(PUSH_STATE) |=> VEC_LOAD)
		else $error("jump not in third cycle");
	AST_GIE_CLEAR: assert property ($rose(PUSH_STATE) |->
		!GLOBAL_IRQ_ENABLE) else $error("enable kept in service");
	AST_ACK_EN: assert property (IRQ_ACK |->
		$past(GLOBAL_IRQ_ENABLE)) else $error("ack while disabled");
	AST_VEC_RANGE: assert property (IRQ_ACK |-> !VEC_ADDR[0] &&
		VEC_ADDR inside {[14'h0002:14'h000E]}) else $error("bad vector");
	// Stop release only honoured in stop mode
	AST_STOP_TAKE: assert property (STOP_RELEASE_IN && STOP_MODE
		|=> STOP_RELEASE) else $error("stop release lost");
	AST_STOP_IGN: assert property (STOP_RELEASE |->
		$past(STOP_MODE)) else $error("stop release outside stop");
	AST_STOP_VEC: assert property (STOP_RELEASE |-> ##[0:1]
		(VEC_LOAD && VEC_ADDR == 14'h0000)) else $error("stop vector");
endmodule : pic_checker
bind pic_ctrl pic_checker pic_checker_inst (.REF_CLK, .RSTN, .STOP_MODE,
	.STOP_RELEASE_IN, .IRQ_ACK, .PUSH_STATE, .VEC_LOAD, .VEC_ADDR,
	.STOP_RELEASE, .GLOBAL_IRQ_ENABLE);

// File: dv/pic_core_model.sv
// Core model pacing instruction completion
`timescale 1ns/10ps
module pic_core_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// High for a slow core
	input  wire logic slow,
	// Current instruction finishing
	output logic      instr_done
);
	logic [1:0] cnt_ff;
	// Free-running instruction phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) cnt_ff <= 2'h0;
		else cnt_ff <= cnt_ff + 2'h1;
	end
	// Slow core finishes one cycle in four, so service must wait
	assign instr_done = !slow || (cnt_ff == 2'h3);
endmodule : pic_core_model

// File: dv/tb.sv
// Self-checking bench for the interrupt control block
`timescale 1ns/10ps
module tb;
	logic       clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
	logic       ser = 1'b0, stop_mode = 1'b0, stop_in = 1'b0;
	logic       ret = 1'b0, slow = 1'b0, done, ack, push, load, rel, gie;
	logic [1:0] addr = 2'h0;
	logic [3:0] wr_data = 4'h0, rd_data;
	logic [6:0] ev = 7'h00; // Source events, priority order
	logic [13:0] vec_addr;
	int         errors = 0, comparisons = 0, cycles = 0, k;
	// Design and core model
	pic_ctrl pic_ctrl_inst (.REF_CLK(clk), .RSTN(rst_n), .ADDR(addr),
		.WR_EN(wr_en), .WR_DATA(wr_data), .RD_EN(rd_en), .RD_DATA(rd_data),
		.EXT_IRQ_IN0(ev[0]), .EXT_IRQ_IN1(ev[1]), .TMRA_OVF(ev[2]),
		.TMRB_OVF(ev[3]), .TMRC_OVF(ev[4]), .ADC_DONE(ev[5]),
		.SERIAL_DONE(ev[6] & !ser), .SERIAL_SUSPEND(ev[6] & ser),
		.STOP_MODE(stop_mode), .STOP_RELEASE_IN(stop_in),
		.RETURN_FROM_IRQ_INSTR(ret), .INSTR_DONE(done), .IRQ_ACK(ack),
		.PUSH_STATE(push), .VEC_LOAD(load), .VEC_ADDR(vec_addr),
		.STOP_RELEASE(rel), .GLOBAL_IRQ_ENABLE(gie));
	pic_core_model pic_core_model_inst (.clk(clk), .rst_n(rst_n),
		.slow(slow), .instr_done(done));
	// Clock and hang guard
	initial forever #50 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			finish_test;
		end
	end
	// Control word image from flags, masks and enable
	function automatic logic [3:0] word(int i, logic [6:0] f, m, logic en);
		case (i)
		0: word = {m[0], f[0], 1'b0, en};
		1: word = {m[2], f[2], m[1], f[1]};
		2: word = {m[4], f[4], m[3], f[3]};
		default: word = {m[6], f[6], m[5], f[5]};
		endcase
	endfunction : word
	// Vector of highest-priority request
	function automatic logic [13:0] vec(logic [6:0] r);
		vec = 14'h0000;
		for (int i = 6; i >= 0; i--) if (r[i]) vec = 14'h0002 + 14'(2 * i);
	endfunction : vec
	task automatic tick;
		@(posedge clk);
		#1;
	endtask : tick
	task automatic check(logic [13:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(int a, logic [3:0] d);
		addr = 2'(a);
		wr_data = d;
		wr_en = 1'b1;
		tick;
		wr_en = 1'b0;
		tick;
	endtask : wr
	// Flag bits of 1 leave flags and 0 clear them; masks and enable always written
	task automatic wr_all(logic [6:0] f, m, logic en);
		for (int i = 0; i < 4; i++) wr(i, word(i, f, m, en));
	endtask : wr_all
	task automatic rd_all(logic [6:0] f, m, logic en);
		for (int i = 0; i < 4; i++) begin
			addr = 2'(i);
			rd_en = 1'b1;
			tick;
			rd_en = 1'b0;
			tick;
			check({10'h000, rd_data}, {10'h000, word(i, f, m, en)});
		end
	endtask : rd_all
	task automatic finish_test;
		if (errors == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : finish_test
	// Main sequence
	initial begin
		logic [6:0] e, m, f;
		void'($urandom(32'h4c1c));
		repeat (2) tick;
		rst_n = 1'b1;
		tick;
		rd_all(7'h00, 7'h7F, 1'b0);
		// Timer A set meets a clear in the same cycle
		addr = 2'h1;
		wr_data = 4'hA; // Both masks kept, both flags cleared
		wr_en = 1'b1;
		ev = 7'h04;
		tick;
		wr_en = 1'b0;
		ev = 7'h00;
		tick;
		rd_all(7'h04, 7'h7F, 1'b0);
		wr_all(7'h00, 7'h7F, 1'b0);
		// Walking top source first, then all masked, then random
		for (int n = 0; n < 24; n++) begin
			m = 7'($urandom);
			e = 7'($urandom);
			slow = 1'($urandom);
			ser = 1'($urandom);
			if (n < 8) m = (n == 7) ? 7'h7F : 7'h00;
			if (n < 8) e = 7'h7F << n % 7;
			wr_all(7'h7F, m, 1'b0);
			ev = e;
			tick;
			ev = 7'h00;
			tick;
			rd_all(e, m, 1'b0);
			wr(0, word(0, 7'h7F, m, 1'b1));
			for (k = 0; k < 20 && ack !== 1'b1; k++) tick;
			f = e & ~m;
			check({13'h0000, ack}, {13'h0000, |f});
			if (|f) begin
				check(vec_addr, vec(f));
				for (k = 0; k < 20 && load !== 1'b1; k++) tick;
				check({13'h0000, gie}, 14'h0000);
			end
			rd_all(e, m, ~|f);
			wr_all(7'h00, m, 1'b0);
			ret = 1'b1;
			tick;
			ret = 1'b0;
			tick;
			check({13'h0000, gie}, 14'h0001);
		end
		// Stop release ignored outside stop mode, then honoured
		stop_in = 1'b1;
		repeat (3) tick;
		check({12'h000, rel, load}, 14'h0000);
		stop_mode = 1'b1;
		tick;
		stop_in = 1'b0;
		for (k = 0; k < 5 && load !== 1'b1; k++) tick;
		check({12'h000, rel, load}, 14'h0003);
		check(vec_addr, 14'h0000);
		finish_test;
	end
endmodule : tb
